/* rtl/bpcs_pin_filter.sv */
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none
module bpcs_pin_filter #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             core_clk, // System clock.
  input  wire logic             nrst,     // Asynchronous reset, active low.
  input  wire logic [WIDTH-1:0] pin_in,   // Raw pin levels.
  output var  logic [WIDTH-1:0] pin_out   // Filtered levels.
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (WIDTH < 1) begin : g_bad_width
    $error("bpcs_pin_filter needs WIDTH of at least one");
  end

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] last_ff;

  // The first stage feeds only the second, so metastability cannot leak.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // A bit changes only when the second and third stages agree.
  genvar gi;
  for (gi = 0; gi < WIDTH; gi++) begin : g_bit
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        pin_out[gi] <= 1'b0;
      end else if (sync_ff[gi] == last_ff[gi]) begin
        pin_out[gi] <= last_ff[gi];
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/bpcs_pkg.sv */
// Shared constants for the breaker position and communication status block.
package bpcs_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  // Hold time for the disconnected report after its switch is released.
  localparam int unsigned DISC_HOLD_S    = 10;
  localparam int unsigned DISC_HOLD_CYC  = DISC_HOLD_S * CLK_HZ;
  // Fieldbus wait time; a plain default, set per installation.
  localparam int unsigned TRIP_UNIT_LINK_INDICATOR_WAIT_MS   = 1000;
  localparam int unsigned TRIP_UNIT_LINK_INDICATOR_WAIT_CYC  = TRIP_UNIT_LINK_INDICATOR_WAIT_MS * CYC_PER_MS;
  // Half period of the flashing internal-bus indicator.
  localparam int unsigned FLASH_HALF_MS  = 500;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CYC_PER_MS;

  // ****************************************************************
  // Data image and write forwarding
  // ****************************************************************
  localparam int unsigned ADDR_W_DEF = 8;
  localparam int unsigned DATA_W_DEF = 16;
  localparam int unsigned NODE_W_DEF = 2;

  // ****************************************************************
  // Position codes and switch patterns (rear, middle, front)
  // ****************************************************************
  localparam logic [1:0] POS_ABSENT    = 2'h0;
  localparam logic [1:0] POS_CONNECTED = 2'h1;
  localparam logic [1:0] POS_TEST      = 2'h2;
  localparam logic [1:0] POS_DISCONN   = 2'h3;

  localparam logic [2:0] SW_NONE   = 3'h0;
  localparam logic [2:0] SW_FRONT  = 3'h1;
  localparam logic [2:0] SW_MIDDLE = 3'h2;
  localparam logic [2:0] SW_REAR   = 3'h4;

  // Position tracker states, one-hot.
  typedef enum logic [4:0] {
    BPCS_ST_ABSENT    = 5'h01,
    BPCS_ST_CONN      = 5'h02,
    BPCS_ST_TEST      = 5'h04,
    BPCS_ST_DISC      = 5'h08,
    BPCS_ST_DISC_HOLD = 5'h10
  } bpcs_pos_e;

endpackage

/* rtl/bpcs_status.sv */
// Status, position and data image logic of the breaker communication module.
//
// What this block does
// - The fieldbus indicator is red while no valid frame is seen or the wait time has run out.
// - A valid frame turns the fieldbus indicator green until the wait time passes without one.
// - The internal-bus indicator is off with no node found and red on an internal bus fault.
// - The internal-bus indicator flashes green when nodes exist but no metering or trip unit.
// - The internal-bus indicator is steady green with the metering unit, trip unit, or both.
// - Rear alone is connected, middle alone test, front alone disconnected, none after reset not present.
// - With no switch actuated while moving, connected or test stays reported until a new position.
// - Disconnected is held for ten seconds after its switch drops, then becomes not present.
// - A local image of the breaker data answers fieldbus reads in the next cycle.
// - Each fieldbus write is passed on to the internal bus node that owns the address.
`timescale 1ns/100ps
`default_nettype none
module bpcs_status
  import bpcs_pkg::*;
#(
  parameter int unsigned ADDR_W    = ADDR_W_DEF,     // Data image address width.
  parameter int unsigned DATA_W    = DATA_W_DEF,     // Data image word width.
  parameter int unsigned NODE_W    = NODE_W_DEF,     // Internal node select width.
  parameter int unsigned WAIT_CYC  = TRIP_UNIT_LINK_INDICATOR_WAIT_CYC,  // Fieldbus wait time in cycles.
  parameter int unsigned HOLD_CYC  = DISC_HOLD_CYC,  // Disconnected hold in cycles.
  parameter int unsigned FLASH_CYC = FLASH_HALF_CYC  // Flash half period in cycles.
) (
  input  wire logic              core_clk,               // System clock.
  input  wire logic              nrst,                   // Reset, active low.
  input  wire logic              frame_valid,            // Valid frame for us, pulse.
  output var  logic              fb_led_red,             // Fieldbus indicator red.
  output var  logic              fb_led_green,           // Fieldbus indicator green.
  input  wire logic              node_found,             // Any internal node found.
  input  wire logic              metering_found,         // Metering unit connected.
  input  wire logic              trip_found,             // Trip unit connected.
  input  wire logic              bus_fault,              // Internal bus fault.
  output var  logic              ib_led_red,             // Internal-bus indicator red.
  output var  logic              ib_led_green,           // Internal-bus indicator green.
  input  wire logic              rear_position_switch,   // Rear micro switch pin.
  input  wire logic              middle_position_switch, // Middle micro switch pin.
  input  wire logic              front_position_switch,  // Front micro switch pin.
  output var  logic [1:0]        position_code,          // Reported carriage position.
  input  wire logic              upd_valid,              // Image update from bus.
  input  wire logic [ADDR_W-1:0] upd_addr,               // Image update address.
  input  wire logic [DATA_W-1:0] upd_data,               // Image update word.
  input  wire logic              rd_req,                 // Fieldbus read request.
  input  wire logic [ADDR_W-1:0] rd_addr,                // Fieldbus read address.
  output var  logic              rd_valid,               // Read answer, pulse.
  output var  logic [DATA_W-1:0] rd_data,                // Read answer word.
  input  wire logic              fb_wr_valid,            // Fieldbus write request.
  input  wire logic [ADDR_W-1:0] fb_wr_addr,             // Fieldbus write address.
  input  wire logic [DATA_W-1:0] fb_wr_data,             // Fieldbus write word.
  output logic                   fb_wr_ready,            // Write can be taken.
  output var  logic              ib_wr_valid,            // Forwarded write valid.
  output var  logic [NODE_W-1:0] ib_wr_node,             // Node owning the address.
  output var  logic [ADDR_W-1:0] ib_wr_addr,             // Forwarded address.
  output var  logic [DATA_W-1:0] ib_wr_data,             // Forwarded word.
  input  wire logic              ib_wr_ready             // Internal bus took it.
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (NODE_W < 1 || NODE_W > ADDR_W) begin : g_bad_node
    $error("bpcs_status needs 1 <= NODE_W <= ADDR_W");
  end
  if (WAIT_CYC < 2 || HOLD_CYC < 2 || FLASH_CYC < 1) begin : g_bad_time
    $error("bpcs_status timing counts are too small");
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // The owning node is taken from the top address bits.
  function automatic logic [NODE_W-1:0] node_of(input logic [ADDR_W-1:0] addr);
    node_of = addr[ADDR_W-1 -: NODE_W];
  endfunction

  // ****************************************************************
  // Fieldbus indicator
  // ****************************************************************
  logic [31:0] wait_cnt_ff;
  // Thirty-two bits serve waits of up to about half a minute at this clock.

  // Each valid frame restarts the wait; expiry drops back to red.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt_ff  <= '0;
      fb_led_green <= 1'b0;
      fb_led_red   <= 1'b1;
    end else if (frame_valid) begin
      wait_cnt_ff  <= WAIT_CYC;
      fb_led_green <= 1'b1;
      fb_led_red   <= 1'b0;
    end else if (wait_cnt_ff == 32'h1) begin
      wait_cnt_ff  <= '0;
      fb_led_green <= 1'b0;
      fb_led_red   <= 1'b1;
    end else if (wait_cnt_ff != '0) begin
      wait_cnt_ff  <= wait_cnt_ff - 32'h1;
    end
  end

  // Green may only end through expiry, never while the wait still runs.
  fb_green_frame_a : assert property (frame_valid |=> fb_led_green && !fb_led_red);
  fb_red_expiry_a : assert property (wait_cnt_ff == 32'h1 && !frame_valid |=> fb_led_red && !fb_led_green);
  fb_green_hold_a : assert property (fb_led_green && wait_cnt_ff > 32'h1 |=> fb_led_green);
  fb_frame_c : cover property (frame_valid ##1 fb_led_green);

  // ****************************************************************
  // Internal-bus indicator
  // ****************************************************************
  logic [31:0] flash_cnt_ff;
  logic        flash_ff;

  // Free-running blink phase; shared by every flashing interval.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flash_cnt_ff <= '0;
      flash_ff     <= 1'b0;
    end else if (flash_cnt_ff >= FLASH_CYC - 1) begin
      flash_cnt_ff <= '0;
      flash_ff     <= ~flash_ff;
    end else begin
      flash_cnt_ff <= flash_cnt_ff + 32'h1;
    end
  end

  // A fault wins over everything, so a broken bus never looks idle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ib_led_red   <= 1'b0;
      ib_led_green <= 1'b0;
    end else if (bus_fault) begin
      ib_led_red   <= 1'b1;
      ib_led_green <= 1'b0;
    end else if (!node_found) begin
      ib_led_red   <= 1'b0;
      ib_led_green <= 1'b0;
    end else if (metering_found || trip_found) begin
      ib_led_red   <= 1'b0;
      ib_led_green <= 1'b1;
    end else begin
      ib_led_red   <= 1'b0;
      ib_led_green <= flash_ff;
    end
  end

  ib_fault_red_a : assert property (bus_fault |=> ib_led_red && !ib_led_green);
  ib_no_node_a : assert property (!bus_fault && !node_found |=> !ib_led_red && !ib_led_green);
  ib_flash_green_a : assert property (!bus_fault && node_found && !metering_found && !trip_found
                                      |=> ib_led_green == $past(flash_ff) && !ib_led_red);
  // A steady answer depends only on the inputs of the cycle before.
  ib_steady_green_a : assert property (!bus_fault && node_found && (metering_found || trip_found)
                                       |=> ib_led_green && !ib_led_red);
  ib_flash_c : cover property (ib_led_green ##1 !ib_led_green && node_found && !bus_fault);

  // ****************************************************************
  // Position switches and tracker
  // ****************************************************************
  logic [2:0] sw_raw;
  logic [2:0] sw_flt;
  bpcs_pos_e  pos_ff;
  bpcs_pos_e  nxt_pos;
  logic [31:0] hold_cnt_ff;
  logic        hold_done;

  assign sw_raw = {rear_position_switch, middle_position_switch, front_position_switch};

  bpcs_pin_filter #(
    .WIDTH (3)
  ) u_sw_filter (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pin_in   (sw_raw),
    .pin_out  (sw_flt)
  );

  // Done one cycle early so that the hold state lasts exactly HOLD_CYC cycles.
  assign hold_done = (hold_cnt_ff >= HOLD_CYC - 1);

  // Double actuation is not a defined position, so it keeps the current state; unlike a gap it never moves disconnected on to the hold or to not present.
  always_comb begin
    nxt_pos = pos_ff;
    case (sw_flt)
      SW_REAR   : nxt_pos = BPCS_ST_CONN;
      SW_MIDDLE : nxt_pos = BPCS_ST_TEST;
      SW_FRONT  : nxt_pos = BPCS_ST_DISC;
      SW_NONE   : begin
        case (pos_ff)
          BPCS_ST_DISC      : nxt_pos = BPCS_ST_DISC_HOLD;
          BPCS_ST_DISC_HOLD : nxt_pos = hold_done ? BPCS_ST_ABSENT : BPCS_ST_DISC_HOLD;
          BPCS_ST_CONN      : nxt_pos = BPCS_ST_CONN;
          BPCS_ST_TEST      : nxt_pos = BPCS_ST_TEST;
          BPCS_ST_ABSENT    : nxt_pos = BPCS_ST_ABSENT;
          default           : nxt_pos = BPCS_ST_ABSENT;
        endcase
      end
      default   : nxt_pos = pos_ff;
    endcase
  end

  // Tracker state and its reported code move together.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pos_ff        <= BPCS_ST_ABSENT;
      position_code <= POS_ABSENT;
    end else begin
      pos_ff <= nxt_pos;
      case (nxt_pos)
        BPCS_ST_CONN      : position_code <= POS_CONNECTED;
        BPCS_ST_TEST      : position_code <= POS_TEST;
        BPCS_ST_DISC      : position_code <= POS_DISCONN;
        BPCS_ST_DISC_HOLD : position_code <= POS_DISCONN;
        default           : position_code <= POS_ABSENT;
      endcase
    end
  end

  // Counts time spent with the disconnected switch released.
  // The counter stops at its end, so it can never wrap during a long hold.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt_ff <= '0;
    end else if (pos_ff == BPCS_ST_DISC_HOLD && !hold_done) begin
      hold_cnt_ff <= hold_cnt_ff + 32'h1;
    end else if (pos_ff != BPCS_ST_DISC_HOLD) begin
      hold_cnt_ff <= '0;
    end
  end

  // Every single-switch pattern decodes; patterns of two or more never move the code.
  pos_decode_a : assert property (sw_flt == SW_REAR |=> position_code == POS_CONNECTED);
  pos_middle_a : assert property (sw_flt == SW_MIDDLE |=> position_code == POS_TEST);
  pos_multi_a : assert property ($countones(sw_flt) > 1 |=> $stable(position_code));
  pos_front_a : assert property (sw_flt == SW_FRONT |=> position_code == POS_DISCONN);
  pos_hold_a : assert property (sw_flt == SW_NONE && pos_ff inside {BPCS_ST_CONN, BPCS_ST_TEST}
                                |=> $stable(position_code));
  disc_hold_a : assert property (pos_ff == BPCS_ST_DISC_HOLD && !hold_done && sw_flt == SW_NONE
                                 |=> position_code == POS_DISCONN);
  disc_expire_a : assert property (pos_ff == BPCS_ST_DISC_HOLD && hold_done && sw_flt == SW_NONE
                                   |=> position_code == POS_ABSENT);
  disc_expire_c : cover property (pos_ff == BPCS_ST_DISC_HOLD ##1 pos_ff == BPCS_ST_ABSENT);

  // ****************************************************************
  // Data image and write forwarding
  // ****************************************************************
  // Not reset: a word never updated reads back as unknown until the bus sends it.
  logic [DATA_W-1:0] image_mem [2**ADDR_W];

  // Bus updates keep the image current; reads never wait on the bus.
  always_ff @(posedge core_clk) begin
    if (upd_valid) begin
      image_mem[upd_addr] <= upd_data;
    end
  end

  // One-cycle read answer; a read of the word being updated gets the old value.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) begin
        rd_data <= image_mem[rd_addr];
      end
    end
  end

  // Only one write is in flight; the master is stalled until it is taken.
  // Trade-off: at most one write every second cycle, but no buffer is needed.
  assign fb_wr_ready = !ib_wr_valid;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ib_wr_valid <= 1'b0;
      ib_wr_node  <= '0;
      ib_wr_addr  <= '0;
      ib_wr_data  <= '0;
    end else if (fb_wr_valid && fb_wr_ready) begin
      ib_wr_valid <= 1'b1;
      ib_wr_node  <= node_of(fb_wr_addr);
      ib_wr_addr  <= fb_wr_addr;
      ib_wr_data  <= fb_wr_data;
    end else if (ib_wr_ready) begin
      ib_wr_valid <= 1'b0;
    end
  end

  // Each read gives one answer pulse, and each taken write leaves exactly once.
  rd_answer_a : assert property (rd_req |=> rd_valid ##1 (rd_valid == $past(rd_req)));
  rd_idle_a : assert property (!rd_req |=> !rd_valid);
  wr_release_a : assert property (ib_wr_valid && ib_wr_ready |=> !ib_wr_valid);
  wr_forward_a : assert property (fb_wr_valid && fb_wr_ready |=> ib_wr_valid
                                  && ib_wr_addr == $past(fb_wr_addr)
                                  && ib_wr_node == $past(fb_wr_addr[ADDR_W-1 -: NODE_W]));
  wr_stall_a : assert property (ib_wr_valid && !ib_wr_ready |=> ib_wr_valid && $stable(ib_wr_data));
  wr_forward_c : cover property (fb_wr_valid && fb_wr_ready ##[1:8] ib_wr_ready);

endmodule
`default_nettype wire

/* test/bpcs_fb_master.sv */
// Fieldbus master model that issues frames, reads and writes to the status block.
`timescale 1ns/100ps
`default_nettype none
module bpcs_fb_master
  import bpcs_pkg::*;
(
  input  wire logic                  core_clk,    // System clock.
  input  wire logic                  fb_wr_ready, // Block can take a write.
  output var  logic                  frame_valid, // Valid frame for the block.
  output var  logic                  rd_req,      // Read request.
  output var  logic [ADDR_W_DEF-1:0] rd_addr,     // Read address.
  output var  logic                  fb_wr_valid, // Write request.
  output var  logic [ADDR_W_DEF-1:0] fb_wr_addr,  // Write address.
  output var  logic [DATA_W_DEF-1:0] fb_wr_data   // Write word.
);
  // Idle at time zero, before any request may be made.
  initial begin
    frame_valid = 1'b0;
    rd_req      = 1'b0;
    rd_addr     = '0;
    fb_wr_valid = 1'b0;
    fb_wr_addr  = '0;
    fb_wr_data  = '0;
  end

  // One frame pulse of a single cycle.
  task automatic send_frame();
    @(posedge core_clk);
    frame_valid <= 1'b1;
    @(posedge core_clk);
    frame_valid <= 1'b0;
  endtask

  // Back-to-back calls keep the strobe up, one read per cycle.
  task automatic read_word(input logic [ADDR_W_DEF-1:0] a);
    @(posedge core_clk);
    rd_req  <= 1'b1;
    rd_addr <= a;
  endtask

  // The address is inverted on release so that a stale value is never trusted.
  task automatic read_idle();
    @(posedge core_clk);
    rd_req  <= 1'b0;
    rd_addr <= ~rd_addr;
  endtask

  // Held until the edge that takes it; released lines show inverted values.
  task automatic write_word(input logic [ADDR_W_DEF-1:0] a, input logic [DATA_W_DEF-1:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    fb_wr_valid <= 1'b1;
    fb_wr_addr  <= a;
    fb_wr_data  <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (fb_wr_ready !== 1'b1 && n < 200);
    fb_wr_valid <= 1'b0;
    fb_wr_addr  <= ~a;
    fb_wr_data  <= ~d;
  endtask
endmodule
`default_nettype wire

/* test/bpcs_status_bench.sv */
// Self-checking bench for the breaker position and communication status block.
`timescale 1ns/100ps
`default_nettype none
module bpcs_status_bench
  import bpcs_pkg::*;
;
  // ****************************************************************
  // Signals and short counts
  // ****************************************************************
  // Short counts keep the run brief; the indicator checks derive from them, but most position waits are fixed figures.
  localparam int unsigned WAIT  = 20;
  localparam int unsigned HOLD  = 30;
  localparam int unsigned FLASH = 4;
  localparam int unsigned CEIL  = 20000;
  logic        core_clk = 1'b0, nrst = 1'b0, node_found = 1'b0, metering_found = 1'b0;
  logic        trip_found = 1'b0, bus_fault = 1'b0, upd_valid = 1'b0, ib_wr_ready = 1'b0;
  logic        frame_valid, fb_led_red, fb_led_green, ib_led_red, ib_led_green;
  logic        rd_req, rd_valid, fb_wr_valid, fb_wr_ready, ib_wr_valid;
  logic [2:0]  sw = 3'h0;
  logic [1:0]  position_code, ib_wr_node;
  logic [7:0]  upd_addr = 8'h00, rd_addr, fb_wr_addr, ib_wr_addr;
  logic [15:0] upd_data = 16'h0000, rd_data, fb_wr_data, ib_wr_data;
  logic [15:0] img [256];
  logic [15:0] rd_q [$];
  logic [25:0] wr_q [$];
  int          n_mismatch = 0, checks_done = 0, cycles = 0;

  always #4 core_clk = ~core_clk;

  bpcs_status #(.WAIT_CYC(WAIT), .HOLD_CYC(HOLD), .FLASH_CYC(FLASH)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .frame_valid(frame_valid),
    .fb_led_red(fb_led_red), .fb_led_green(fb_led_green), .node_found(node_found),
    .metering_found(metering_found), .trip_found(trip_found), .bus_fault(bus_fault),
    .ib_led_red(ib_led_red), .ib_led_green(ib_led_green), .rear_position_switch(sw[2]),
    .middle_position_switch(sw[1]), .front_position_switch(sw[0]),
    .position_code(position_code), .upd_valid(upd_valid), .upd_addr(upd_addr),
    .upd_data(upd_data), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid),
    .rd_data(rd_data), .fb_wr_valid(fb_wr_valid), .fb_wr_addr(fb_wr_addr),
    .fb_wr_data(fb_wr_data), .fb_wr_ready(fb_wr_ready), .ib_wr_valid(ib_wr_valid),
    .ib_wr_node(ib_wr_node), .ib_wr_addr(ib_wr_addr), .ib_wr_data(ib_wr_data),
    .ib_wr_ready(ib_wr_ready));

  bpcs_fb_master pm_u (
    .core_clk(core_clk), .fb_wr_ready(fb_wr_ready), .frame_valid(frame_valid),
    .rd_req(rd_req), .rd_addr(rd_addr), .fb_wr_valid(fb_wr_valid),
    .fb_wr_addr(fb_wr_addr), .fb_wr_data(fb_wr_data));

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Moves just past an edge so that outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Bus side stalls at random, so forwarded writes wait for acceptance.
  always @(posedge core_clk) ib_wr_ready <= 1'($urandom);

  // Results are matched against the oldest note as they appear; a hang ends the run.
  always @(posedge core_clk) begin
    cycles++;
    if (nrst === 1'b1 && rd_valid === 1'b1) begin
      check("read data", rd_data, rd_q.size() > 0 ? rd_q.pop_front() : 32'h1_0000);
    end
    if (nrst === 1'b1 && ib_wr_valid === 1'b1 && ib_wr_ready === 1'b1) begin
      check("forwarded write", {ib_wr_node, ib_wr_addr, ib_wr_data},
            wr_q.size() > 0 ? wr_q.pop_front() : 32'hFC00_0000);
    end
    if (cycles >= CEIL) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // A second frame mid-wait restarts the wait; green holds exactly WAIT cycles.
  task automatic fb_led_run();
    check("fb leds", {fb_led_red, fb_led_green}, 2'b10);
    pm_u.send_frame();
    tick(WAIT / 2);
    pm_u.send_frame();
    tick(0);
    for (int k = 0; k < WAIT; k++) begin
      check("fb leds", {fb_led_red, fb_led_green}, 2'b01);
      tick(1);
    end
    check("fb leds", {fb_led_red, fb_led_green}, 2'b10);
  endtask

  // Every combination of the four flags; flashing is high half of each period.
  task automatic ib_sweep();
    logic [3:0] f;
    logic [1:0] e;
    int         ones;
    for (int i = 0; i < 16; i++) begin
      f = 4'(i);
      @(posedge core_clk);
      {bus_fault, node_found, metering_found, trip_found} <= f;
      tick(2);
      e = f[3] ? 2'b10 : !f[2] ? 2'b00 : (f[1] | f[0]) ? 2'b01 : 2'b11;
      if (e != 2'b11) begin
        check("ib leds", {ib_led_red, ib_led_green}, e);
      end else begin
        ones = 0;
        repeat (2 * FLASH) begin
          if (ib_led_green === 1'b1 && ib_led_red === 1'b0) ones++;
          tick(1);
        end
        check("flash high count", ones, FLASH);
      end
    end
  endtask

  // Switch patterns with the wait after each and the position then expected.
  task automatic pos_run();
    logic [2:0] pat [11];
    logic [1:0] pos [11];
    int         wt  [11];
    pat = '{SW_REAR, SW_NONE, SW_MIDDLE, SW_REAR | SW_MIDDLE, SW_FRONT, SW_NONE, SW_NONE,
            SW_FRONT, SW_NONE, SW_MIDDLE, SW_FRONT | SW_MIDDLE};
    pos = '{POS_CONNECTED, POS_CONNECTED, POS_TEST, POS_TEST, POS_DISCONN, POS_DISCONN,
            POS_ABSENT, POS_DISCONN, POS_DISCONN, POS_TEST, POS_TEST};
    wt  = '{8, HOLD + 10, 8, 8, 8, 20, 25, 8, 12, 8, 8};
    for (int i = 0; i < 11; i++) begin
      @(posedge core_clk);
      sw <= pat[i];
      tick(wt[i]);
      check("position", position_code, pos[i]);
    end
  endtask

  // Image filled from the internal bus, then read back to back.
  task automatic rd_run();
    logic [7:0]  a [8];
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      a[i] = 8'($urandom);
      d = 16'($urandom);
      img[a[i]] = d;
      @(posedge core_clk);
      upd_valid <= 1'b1;
      upd_addr  <= a[i];
      upd_data  <= d;
    end
    @(posedge core_clk);
    upd_valid <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd_q.push_back(img[a[i]]);
      pm_u.read_word(a[i]);
    end
    pm_u.read_idle();
    tick(3);
    check("reads left", rd_q.size(), 0);
  endtask

  // Writes to every node, back to back, against a stalling internal bus.
  task automatic wr_run();
    logic [7:0]  a;
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      a = {2'(i), 6'($urandom)};
      d = 16'($urandom);
      wr_q.push_back({a[7:6], a, d});
      pm_u.write_word(a, d);
    end
    tick(40);
    check("writes left", wr_q.size(), 0);
  endtask

  initial begin
    void'($urandom(87));
    repeat (19) @(posedge core_clk);
    #1;
    check("reset outputs", {fb_led_red, fb_led_green, ib_led_red, ib_led_green, position_code,
          rd_valid, fb_wr_ready, ib_wr_valid}, 9'b1_0000_0010);
    @(posedge core_clk);
    nrst <= 1'b1;
    fb_led_run();
    ib_sweep();
    pos_run();
    rd_run();
    wr_run();
    end_of_test();
  end
endmodule
`default_nettype wire
